// ---- external_data_memory_interface.sv ----
`timescale 1ns/10ps
module external_data_memory_interface #(
  parameter int ONCHIP_EXPANDED_RAM_DEPTH = ext_mem_pkg::ONCHIP_EXPANDED_RAM_BYTES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire ext_mem_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire ext_mem_pkg::ptr_cmd_t ptr_cmd,
  output logic [15:0] ptr_value,
  input wire ext_mem_pkg::movx_req_t movx_req,
  output logic movx_busy,
  output logic movx_done,
  output logic [7:0] movx_rdata,
  output logic [7:0] data_high,
  input wire logic [7:0] p0_in,
  output ext_mem_pkg::bus_pins_t pins
);

  if (ONCHIP_EXPANDED_RAM_DEPTH < 256 || ONCHIP_EXPANDED_RAM_DEPTH > (1 << ext_mem_pkg::ONCHIP_EXPANDED_RAM_AW)) begin : g_check
    $error("onchip_expanded_ram depth out of range");
  end

  ext_mem_pkg::core_state_t st;
  ext_mem_pkg::core_state_t next_st;
  logic [7:0] onchip_expanded_ram_rdata;
  logic onchip_expanded_ram_we;
  logic [ext_mem_pkg::ONCHIP_EXPANDED_RAM_AW-1:0] onchip_expanded_ram_addr;
  logic onchip_expanded_ram_hit;

  function automatic logic [2:0] ale_len_m1(input logic [7:0] timing);
    ale_len_m1 = {1'b0, timing[ext_mem_pkg::ALE_W_HI:ext_mem_pkg::ALE_W_LO]};
  endfunction

  function automatic logic [2:0] setup_len_m1(input logic [7:0] timing);
    if (timing[ext_mem_pkg::SETUP_HOLD_BIT]) begin
      setup_len_m1 = 3'(ext_mem_pkg::SETUP_LONG_CYC - 1);
    end else begin
      setup_len_m1 = 3'(ext_mem_pkg::SETUP_SHORT_CYC - 1);
    end
  endfunction

  function automatic logic is_ext(input ext_mem_pkg::seq_state_t s);
    is_ext = (s == ext_mem_pkg::s_ale_hi) || (s == ext_mem_pkg::s_ale_lo) ||
             (s == ext_mem_pkg::s_setup) || (s == ext_mem_pkg::s_strobe) || (s == ext_mem_pkg::s_hold);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // on-chip expanded ram

  assign onchip_expanded_ram_hit = (32'(st.addr) < ONCHIP_EXPANDED_RAM_DEPTH);
  assign onchip_expanded_ram_we = (st.state == ext_mem_pkg::s_onchip_expanded_ram) && st.write && onchip_expanded_ram_hit; // R1
  assign onchip_expanded_ram_addr = st.addr[ext_mem_pkg::ONCHIP_EXPANDED_RAM_AW-1:0]; // R12

  onchip_ram #(
    .DEPTH(ONCHIP_EXPANDED_RAM_DEPTH),
    .AW(ext_mem_pkg::ONCHIP_EXPANDED_RAM_AW)
  ) u_ram (
    .mclk(mclk),
    .wr_en(onchip_expanded_ram_we),
    .addr(onchip_expanded_ram_addr),
    .wdata(st.wlo),
    .rdata(onchip_expanded_ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer and registers

  always_comb begin
    logic noaddr;
    logic wide;
    logic ale_on;
    logic read_strobe;
    noaddr = st.timing[ext_mem_pkg::MODE_HI];
    wide = st.timing[ext_mem_pkg::MODE_LO];
    ale_on = 1'b0;
    read_strobe = 1'b0;
    next_st = st;
    next_st.s1 = p0_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.filt = st.s3;
    end

    if (sfr_req.wr) begin
      case (sfr_req.addr)
        ext_mem_pkg::ADDR_TIMING: next_st.timing = sfr_req.wdata;
        ext_mem_pkg::ADDR_AUX1: next_st.aux1 = sfr_req.wdata;
        ext_mem_pkg::ADDR_AUX2: next_st.aux2 = sfr_req.wdata & ext_mem_pkg::AUX2_READ_MASK;
        ext_mem_pkg::ADDR_AUX3: next_st.aux3 = sfr_req.wdata;
        ext_mem_pkg::ADDR_DATA_HIGH: next_st.data_high_byte = sfr_req.wdata;
        default: next_st.data_high_byte = next_st.data_high_byte;
      endcase
    end
    next_st.sfr_hit = 1'b0;
    next_st.sfr_rdata = 8'h00;
    if (sfr_req.rd) begin
      next_st.sfr_hit = 1'b1;
      case (sfr_req.addr)
        ext_mem_pkg::ADDR_TIMING: next_st.sfr_rdata = st.timing;
        ext_mem_pkg::ADDR_AUX1: next_st.sfr_rdata = st.aux1;
        ext_mem_pkg::ADDR_AUX2: next_st.sfr_rdata = st.aux2;
        ext_mem_pkg::ADDR_AUX3: next_st.sfr_rdata = st.aux3;
        ext_mem_pkg::ADDR_DATA_HIGH: next_st.sfr_rdata = st.data_high_byte;
        default: next_st.sfr_hit = 1'b0;
      endcase
    end

    // pointer ops act on whichever pointer is selected when they arrive
    if (ptr_cmd.load || ptr_cmd.inc) begin
      if (st.aux1[ext_mem_pkg::PTR_SEL_BIT]) begin // R9
        next_st.ptr1 = ptr_cmd.load ? ptr_cmd.value : st.ptr1 + 16'h0001; // R10
      end else begin
        next_st.ptr0 = ptr_cmd.load ? ptr_cmd.value : st.ptr0 + 16'h0001; // R10
      end
    end

    case (st.state)
      ext_mem_pkg::s_idle: begin
        if (movx_req.req) begin
          next_st.write = movx_req.write;
          next_st.paged = movx_req.paged;
          next_st.wlo = movx_req.wdata;
          next_st.whi = st.data_high_byte; // R17
          next_st.second = 1'b0;
          if (movx_req.paged) begin
            next_st.addr = {8'h00, movx_req.ri}; // R11
          end else begin
            next_st.addr = st.aux1[ext_mem_pkg::PTR_SEL_BIT] ? st.ptr1 : st.ptr0; // R10
          end
          if (!st.aux1[ext_mem_pkg::EXT_RAM_BIT]) begin
            next_st.state = ext_mem_pkg::s_onchip_expanded_ram; // R1
          end else if (!noaddr) begin
            next_st.state = ext_mem_pkg::s_ale_hi; // R2
            next_st.cnt = ale_len_m1(st.timing); // R3
          end else begin
            next_st.state = ext_mem_pkg::s_setup; // R15
            next_st.cnt = setup_len_m1(st.timing); // R4
          end
        end
      end
      ext_mem_pkg::s_onchip_expanded_ram: begin
        next_st.state = st.write ? ext_mem_pkg::s_done : ext_mem_pkg::s_xwait;
      end
      ext_mem_pkg::s_xwait: begin
        next_st.movx_rdata = onchip_expanded_ram_hit ? onchip_expanded_ram_rdata : ext_mem_pkg::ONCHIP_EXPANDED_RAM_MISS_DATA;
        next_st.state = ext_mem_pkg::s_done;
      end
      ext_mem_pkg::s_ale_hi: begin
        next_st.cnt = st.cnt - 3'd1;
        if (st.cnt == 3'd0) begin
          next_st.state = ext_mem_pkg::s_ale_lo; // R13
          next_st.cnt = ale_len_m1(st.timing); // R3
        end
      end
      ext_mem_pkg::s_ale_lo: begin
        next_st.cnt = st.cnt - 3'd1;
        if (st.cnt == 3'd0) begin
          next_st.state = ext_mem_pkg::s_setup;
          next_st.cnt = setup_len_m1(st.timing); // R4
        end
      end
      ext_mem_pkg::s_setup: begin
        next_st.cnt = st.cnt - 3'd1;
        if (st.cnt == 3'd0) begin
          next_st.state = ext_mem_pkg::s_strobe;
          next_st.cnt = st.timing[ext_mem_pkg::RW_W_HI:ext_mem_pkg::RW_W_LO]; // R5
        end
      end
      ext_mem_pkg::s_strobe: begin
        next_st.cnt = st.cnt - 3'd1;
        if (st.cnt == 3'd0) begin
          read_strobe = !st.write;
          next_st.state = ext_mem_pkg::s_hold;
          next_st.cnt = setup_len_m1(st.timing); // R4
        end
      end
      ext_mem_pkg::s_hold: begin
        next_st.cnt = st.cnt - 3'd1;
        if (st.cnt == 3'd0) begin
          if (wide && !st.second) begin
            next_st.second = 1'b1; // R17
            next_st.state = ext_mem_pkg::s_setup;
            next_st.cnt = setup_len_m1(st.timing);
          end else begin
            next_st.state = ext_mem_pkg::s_done;
          end
        end
      end
      ext_mem_pkg::s_done: begin
        next_st.state = ext_mem_pkg::s_idle;
      end
      default: begin
        next_st.state = ext_mem_pkg::s_idle;
      end
    endcase

    // sample on the last strobe cycle; the bus capture beats a same-cycle sfr write
    if (read_strobe) begin
      if (st.second) begin
        next_st.data_high_byte = st.filt; // R17
      end else begin
        next_st.movx_rdata = st.filt; // R18
      end
    end

    next_st.busy = (next_st.state != ext_mem_pkg::s_idle);
    next_st.done = (next_st.state == ext_mem_pkg::s_done);
    next_st.ptr_value = next_st.aux1[ext_mem_pkg::PTR_SEL_BIT] ? next_st.ptr1 : next_st.ptr0; // R9

    // pins follow the next state so that every pin leaves a flip-flop
    // on-chip moves and idle keep every pin at its resting value
    ale_on = (next_st.state == ext_mem_pkg::s_ale_hi);
    next_st.pins.p0_oe = 1'b0; // R16
    next_st.pins.p2_oe = 1'b0;
    next_st.pins.addr_oe = 1'b0;
    if (next_st.state == ext_mem_pkg::s_ale_hi || next_st.state == ext_mem_pkg::s_ale_lo) begin
      next_st.pins.p0_out = next_st.addr[7:0]; // R13
      next_st.pins.p0_oe = 1'b1;
    end else if (is_ext(next_st.state)) begin
      next_st.pins.p0_out = next_st.second ? next_st.whi : next_st.wlo; // R17
      next_st.pins.p0_oe = next_st.write; // R18
    end
    if (is_ext(next_st.state) && !next_st.timing[ext_mem_pkg::MODE_HI] && !next_st.paged) begin
      next_st.pins.p2_out = next_st.addr[15:8]; // R14
      next_st.pins.p2_oe = 1'b1; // R14
    end
    if (is_ext(next_st.state) && next_st.timing[ext_mem_pkg::MODE_HI] &&
        next_st.aux2[ext_mem_pkg::ADDR_OUT_BIT]) begin
      next_st.pins.p5_out = next_st.addr[7:0]; // R7
      next_st.pins.p6_out = next_st.addr[13:8]; // R7
      next_st.pins.p7_out = next_st.addr[15:14]; // R7
      next_st.pins.addr_oe = 1'b1; // R7
    end
    next_st.pins.ale_p46 = ale_on ^ next_st.aux2[ext_mem_pkg::ALE_POL_BIT]; // R6
    next_st.pins.ale_p47 = ale_on ^ next_st.aux2[ext_mem_pkg::ALE_POL_BIT]; // R6
    next_st.pins.ale_p46_oe = !next_st.aux3[ext_mem_pkg::ALE_PIN_BIT]; // R8
    next_st.pins.ale_p47_oe = next_st.aux3[ext_mem_pkg::ALE_PIN_BIT]; // R8
    next_st.pins.rd_n = !(next_st.state == ext_mem_pkg::s_strobe && !next_st.write); // R5
    next_st.pins.wr_n = !(next_st.state == ext_mem_pkg::s_strobe && next_st.write); // R5
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
      st.state <= ext_mem_pkg::s_idle;
      st.timing <= ext_mem_pkg::RESET_TIMING;
      st.aux1 <= ext_mem_pkg::RESET_AUX1;
      st.aux2 <= ext_mem_pkg::RESET_AUX2;
      st.aux3 <= ext_mem_pkg::RESET_AUX3;
      st.data_high_byte <= ext_mem_pkg::RESET_DATA_HIGH;
      st.pins.rd_n <= 1'b1;
      st.pins.wr_n <= 1'b1;
      st.pins.ale_p46_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign sfr_rdata = st.sfr_rdata;
  assign sfr_hit = st.sfr_hit;
  assign ptr_value = st.ptr_value;
  assign movx_busy = st.busy;
  assign movx_done = st.done;
  assign movx_rdata = st.movx_rdata;
  assign data_high = st.data_high_byte;
  assign pins = st.pins;

endmodule

// ---- ext_mem_pkg.sv ----
// Contract
// R1: select bit 0 sends data moves to on-chip 3840-byte RAM, 1 to the bus.
// R2: mode field picks muxed or no-address access, with 8- or 16-bit data.
// R3: in muxed modes latch strobe high and low phases last 1 to 4 cycles.
// R4: setup and hold around read/write strobes is 1 cycle, or 2 when set.
// R5: read and write strobes stay active for strobe width code plus one cycles.
// R6: polarity bit 0 gives high latch pulse, 1 gives inverted low pulse.
// R7: no-address modes may drive the address on ports 5, 6 and 7.
// R8: pin select bit puts the latch strobe on P4.6 or P4.7.
// R9: two independent 16-bit data pointers, one select bit picks the active one.
// R10: increment, load, table read, moves and jump all use the selected pointer.
// R11: paged 8-bit moves reach the lowest 256 bytes of the same on-chip RAM.
// R12: 64KB pointer-addressed data space, with 3840 bytes of it on chip.
// R13: muxed modes share port 0 between low address and data; latch on fall.
// R14: 16-bit addressed external moves hold the high address on port 2.
// R15: no-address modes skip the address phase and only move data.
// R16: on-chip RAM moves leave every external pin unchanged.
// R17: 16-bit data modes carry the upper byte through the data high register.
// R18: write data brackets the strobe; read data is sampled before strobe end.
package ext_mem_pkg;

  localparam logic [7:0] ADDR_TIMING = 8'h8f;
  localparam logic [7:0] ADDR_AUX1 = 8'ha2;
  localparam logic [7:0] ADDR_AUX2 = 8'ha3;
  localparam logic [7:0] ADDR_AUX3 = 8'ha4;
  localparam logic [7:0] ADDR_DATA_HIGH = 8'hba;

  localparam logic [7:0] RESET_TIMING = 8'h00;
  localparam logic [7:0] RESET_AUX1 = 8'h00;
  localparam logic [7:0] RESET_AUX2 = 8'h00;
  localparam logic [7:0] RESET_AUX3 = 8'h00;
  localparam logic [7:0] RESET_DATA_HIGH = 8'h00;
  // bits 5:4 of aux two are dropped on write and read back as zero
  localparam logic [7:0] AUX2_READ_MASK = 8'hcf;

  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int ALE_W_HI = 5;
  localparam int ALE_W_LO = 4;
  localparam int SETUP_HOLD_BIT = 3;
  localparam int RW_W_HI = 2;
  localparam int RW_W_LO = 0;
  localparam int EXT_RAM_BIT = 1;
  localparam int PTR_SEL_BIT = 0;
  localparam int ALE_POL_BIT = 7;
  localparam int ADDR_OUT_BIT = 6;
  localparam int ALE_PIN_BIT = 3;

  // mode field: bit 1 set means no address phase, bit 0 set means 16-bit data
  localparam int MODE_NOADDR_BIT = 1;
  localparam int MODE_WIDE_BIT = 0;

  localparam int ONCHIP_EXPANDED_RAM_BYTES = 3840;
  localparam int ONCHIP_EXPANDED_RAM_AW = 12;
  localparam logic [7:0] ONCHIP_EXPANDED_RAM_MISS_DATA = 8'hff;

  // strobe setup/hold in sysclk cycles
  localparam int SETUP_SHORT_CYC = 1;
  localparam int SETUP_LONG_CYC = 2;

  typedef enum logic [8:0] {
    s_idle = 9'h001,
    s_onchip_expanded_ram = 9'h002,
    s_xwait = 9'h004,
    s_ale_hi = 9'h008,
    s_ale_lo = 9'h010,
    s_setup = 9'h020,
    s_strobe = 9'h040,
    s_hold = 9'h080,
    s_done = 9'h100
  } seq_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic inc;
    logic load;
    logic [15:0] value;
  } ptr_cmd_t;

  typedef struct packed {
    logic req;
    logic write;
    logic paged;
    logic [7:0] ri;
    logic [7:0] wdata;
  } movx_req_t;

  typedef struct packed {
    logic [7:0] p0_out;
    logic p0_oe;
    logic [7:0] p2_out;
    logic p2_oe;
    logic ale_p46;
    logic ale_p46_oe;
    logic ale_p47;
    logic ale_p47_oe;
    logic rd_n;
    logic wr_n;
    logic [7:0] p5_out;
    logic [5:0] p6_out;
    logic [1:0] p7_out;
    logic addr_oe;
  } bus_pins_t;

  typedef struct packed {
    seq_state_t state;
    logic [2:0] cnt;
    logic second;
    logic write;
    logic paged;
    logic [15:0] addr;
    logic [7:0] wlo;
    logic [7:0] whi;
    logic [7:0] timing;
    logic [7:0] aux1;
    logic [7:0] aux2;
    logic [7:0] aux3;
    logic [7:0] data_high_byte;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [15:0] ptr_value;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic [7:0] movx_rdata;
    logic busy;
    logic done;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] filt;
    bus_pins_t pins;
  } core_state_t;

endpackage

// ---- onchip_ram.sv ----
`timescale 1ns/10ps
module onchip_ram #(
  parameter int DEPTH = 3840,
  parameter int AW = 12
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // contents are not cleared by reset, as in any sram
  logic [7:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

// ---- ext_mem_chk.sv ----
`timescale 1ns/10ps
module ext_mem_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire ext_mem_pkg::sfr_req_t sfr_req,
  input wire ext_mem_pkg::ptr_cmd_t ptr_cmd,
  input wire logic [15:0] ptr_value,
  input wire ext_mem_pkg::movx_req_t movx_req,
  input wire logic movx_busy,
  input wire logic movx_done,
  input wire ext_mem_pkg::bus_pins_t pins
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////
  // shadow copies follow sfr writes, so no extra design ports are needed
  logic [7:0] tmg;
  logic ext, pol, psel, ao, strb, act, aux1_wr;
  logic [3:0] lowcnt, alecnt;
  logic [1:0] quiet;
  assign strb = !(pins.rd_n && pins.wr_n);
  assign act = (pins.ale_p47_oe ? pins.ale_p47 : pins.ale_p46) ^ pol;
  assign aux1_wr = sfr_req.wr && sfr_req.addr == ext_mem_pkg::ADDR_AUX1;
  always_ff @(posedge mclk) begin
    if (rst) begin
      tmg <= 8'h00;
      ext <= 1'b0;
      pol <= 1'b0;
      psel <= 1'b0;
      ao <= 1'b0;
      quiet <= 2'h0;
    end else begin
      if (sfr_req.wr && sfr_req.addr == ext_mem_pkg::ADDR_TIMING) tmg <= sfr_req.wdata;
      if (aux1_wr) ext <= sfr_req.wdata[ext_mem_pkg::EXT_RAM_BIT];
      if (sfr_req.wr && sfr_req.addr == ext_mem_pkg::ADDR_AUX2) pol <= sfr_req.wdata[7];
      if (sfr_req.wr && sfr_req.addr == ext_mem_pkg::ADDR_AUX2) ao <= sfr_req.wdata[ext_mem_pkg::ADDR_OUT_BIT];
      if (sfr_req.wr && sfr_req.addr == ext_mem_pkg::ADDR_AUX3) psel <= sfr_req.wdata[3];
      // pins update on the same edge as register writes; rest checks still wait a few idle cycles
      quiet <= (sfr_req.wr || movx_busy) ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
    end
    lowcnt <= strb ? lowcnt + 4'h1 : 4'h0;
    alecnt <= (act && movx_busy) ? alecnt + 4'h1 : 4'h0;
  end
  ////////////////////////
  sequence setup_one; !strb ##1 strb; endsequence
  sequence setup_two; !strb ##1 !strb ##1 strb; endsequence
  sequence hold_two; !movx_done ##1 movx_done; endsequence
  chk_strobe_width: assert property ($fell(strb) |-> lowcnt == {1'b0, tmg[2:0]} + 4'h1)
    else $error("strobe width wrong");
  chk_hold_time: assert property ($fell(strb) && !tmg[6] |=> if (tmg[3]) hold_two else movx_done)
    else $error("strobe hold wrong");
  chk_setup_time: assert property ($rose(movx_busy) && ext && tmg[7] |-> if (tmg[3]) setup_two else setup_one)
    else $error("strobe setup wrong");
  chk_ale_width: assert property ($fell(act) && movx_busy |-> alecnt == {2'b00, tmg[5:4]} + 4'h1)
    else $error("latch strobe width wrong");
  chk_ale_rest: assert property (quiet == 2'h3 && !movx_busy |-> !act)
    else $error("latch strobe rest level wrong");
  chk_ale_pin: assert property (quiet == 2'h3 |-> pins.ale_p47_oe == psel && pins.ale_p46_oe == !psel)
    else $error("latch strobe pin wrong");
  chk_onchip_expanded_ram_quiet: assert property (movx_busy && !ext |-> $stable(pins))
    else $error("pins moved on chip access");
  chk_noaddr_quiet: assert property (movx_busy && ext && tmg[7] |-> !act && !pins.p2_oe)
    else $error("address phase in no address mode");
  chk_high_addr: assert property ($rose(movx_busy) && ext && !tmg[7] && !$past(movx_req.paged)
    |-> pins.p2_oe && pins.p2_out == ptr_value[15:8])
    else $error("high address missing");
  chk_paged_high: assert property ($rose(movx_busy) && ext && $past(movx_req.paged) |-> !pins.p2_oe)
    else $error("high address driven on paged move");
  chk_noaddr_addr: assert property ($rose(movx_busy) && ext && tmg[7] && ao && !$past(movx_req.paged)
    |-> pins.addr_oe && {pins.p7_out, pins.p6_out, pins.p5_out} == ptr_value)
    else $error("no address mode address pins wrong");
  chk_high_hold: assert property ($past(pins.p2_oe) && pins.p2_oe |-> $stable(pins.p2_out))
    else $error("high address moved");
  chk_ptr_inc: assert property (ptr_cmd.inc && !ptr_cmd.load && !aux1_wr
    |=> ptr_value == $past(ptr_value) + 16'h0001)
    else $error("pointer increment wrong");
endmodule

// ---- ext_sram_model.sv ----
`timescale 1ns/10ps
module ext_sram_model (
  input wire logic mclk,
  input wire ext_mem_pkg::bus_pins_t pins,
  input wire logic ale_inv,
  input wire logic wide,
  input wire logic [1:0] lag,
  output logic [7:0] p0_in
);
  logic [7:0] mem [512];
  logic [7:0] latch = 8'h00;
  logic [7:0] last = 8'h00;
  logic [1:0] cnt = 2'h0;
  logic ph = 1'b0;
  logic sp = 1'b0;
  logic ale, drive;
  logic [8:0] idx;
  assign ale = (pins.ale_p47_oe ? pins.ale_p47 : pins.ale_p46) ^ ale_inv;
  assign idx = {ph, pins.addr_oe ? pins.p5_out : latch};
  assign drive = !pins.rd_n && cnt >= lag;
  // a released bus shows the inverse of its last value, never a held copy
  assign p0_in = drive ? mem[idx] : ~last;
  // plain always: the state here starts from declaration values, as the model has no reset
  always @(posedge mclk) begin
    if (ale) latch <= pins.p0_out;
    if (!pins.wr_n) mem[idx] <= pins.p0_out;
    if (drive) last <= mem[idx];
    cnt <= pins.rd_n ? 2'h0 : (cnt == 2'h3 ? cnt : cnt + 2'h1);
    sp <= !(pins.rd_n && pins.wr_n);
    if (wide && sp && pins.rd_n && pins.wr_n) ph <= !ph;
  end
endmodule

// ---- test_external_data_memory_interface.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_external_data_memory_interface;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  ext_mem_pkg::sfr_req_t sfr_req = '0;
  ext_mem_pkg::ptr_cmd_t ptr_cmd = '0;
  ext_mem_pkg::movx_req_t movx_req = '0;
  ext_mem_pkg::bus_pins_t pins;
  logic [7:0] sfr_rdata, movx_rdata, data_high, p0_in;
  logic [15:0] ptr_value;
  logic sfr_hit, movx_busy, movx_done;
  logic ale_inv = 1'b0;
  logic wide = 1'b0;
  logic [1:0] lag = 2'h0;
  int fail_count = 0;
  int compares = 0;
  always #2 mclk = ~mclk;
  external_data_memory_interface i_dut (.mclk, .rst, .sfr_req, .sfr_rdata, .sfr_hit, .ptr_cmd, .ptr_value,
    .movx_req, .movx_busy, .movx_done, .movx_rdata, .data_high, .p0_in, .pins);
  ext_sram_model i_mem (.mclk, .pins, .ale_inv, .wide, .lag, .p0_in);
  ////////////////////////
  task automatic results();
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_req <= '{!w, w, a, d};
    @(posedge mclk);
    sfr_req <= '0;
    #1;
  endtask
  task automatic ptr(input logic i, input logic l, input logic [15:0] v, input logic [15:0] e);
    @(posedge mclk);
    ptr_cmd <= '{i, l, v};
    @(posedge mclk);
    ptr_cmd <= '0;
    #1;
    `CHK("pointer", e, ptr_value)
  endtask
  task automatic movx(input logic w, input logic p, input logic [7:0] ri, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    movx_req <= '{1'b1, w, p, ri, d};
    @(posedge mclk);
    movx_req <= '0;
    while (movx_done !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 300) begin
      fail_count++;
      results();
    end
  endtask
  ////////////////////////
  task automatic t_regs();
    logic [7:0] a [5] = '{ext_mem_pkg::ADDR_TIMING, ext_mem_pkg::ADDR_AUX1, ext_mem_pkg::ADDR_AUX2,
      ext_mem_pkg::ADDR_AUX3, ext_mem_pkg::ADDR_DATA_HIGH};
    for (int k = 0; k < 5; k++) begin
      sfr(1'b0, a[k], 8'h00);
      `CHK("reset value", 8'h00, sfr_rdata)
      sfr(1'b1, a[k], 8'hff);
      sfr(1'b0, a[k], 8'h00);
      `CHK("read back", k == 2 ? ext_mem_pkg::AUX2_READ_MASK : 8'hff, sfr_rdata)
      `CHK("hit", 1'b1, sfr_hit)
      sfr(1'b1, a[k], 8'h00);
    end
    sfr(1'b0, 8'h90, 8'h00);
    `CHK("unmapped hit", 1'b0, sfr_hit)
    `CHK("unmapped data", 8'h00, sfr_rdata)
  endtask
  task automatic t_ptr();
    ptr(1'b0, 1'b1, 16'h1234, 16'h1234);
    ptr(1'b1, 1'b0, 16'h0000, 16'h1235);
    sfr(1'b1, ext_mem_pkg::ADDR_AUX1, 8'h01);
    @(posedge mclk);
    ptr(1'b1, 1'b1, 16'hfffe, 16'hfffe);
    ptr(1'b1, 1'b0, 16'h0000, 16'hffff);
    ptr(1'b1, 1'b0, 16'h0000, 16'h0000);
    sfr(1'b1, ext_mem_pkg::ADDR_AUX1, 8'h00);
    @(posedge mclk);
    #1;
    `CHK("pointer zero kept", 16'h1235, ptr_value)
  endtask
  task automatic t_onchip_expanded_ram();
    ptr(1'b0, 1'b1, 16'h0eff, 16'h0eff);
    movx(1'b1, 1'b0, 8'h00, 8'h5a);
    movx(1'b0, 1'b0, 8'h00, 8'h00);
    `CHK("on chip top", 8'h5a, movx_rdata)
    ptr(1'b0, 1'b1, 16'h0f00, 16'h0f00);
    movx(1'b1, 1'b0, 8'h00, 8'h11);
    movx(1'b0, 1'b0, 8'h00, 8'h00);
    `CHK("on chip miss", ext_mem_pkg::ONCHIP_EXPANDED_RAM_MISS_DATA, movx_rdata)
    movx(1'b1, 1'b1, 8'h10, 8'h3c);
    ptr(1'b0, 1'b1, 16'h0010, 16'h0010);
    movx(1'b0, 1'b0, 8'h00, 8'h00);
    `CHK("paged shared", 8'h3c, movx_rdata)
  endtask
  task automatic t_ext();
    // reads need a strobe of five cycles plus the model lag or more: the pin input is synchronised and filtered
    logic [7:0] cfg [4] = '{8'h05, 8'h7e, 8'h8d, 8'hd7};
    logic [15:0] a;
    for (int k = 0; k < 4; k++) begin
      a = {8'h71, 5'h00, k[2:0]};
      ale_inv = k[0];
      wide = cfg[k][6];
      lag = {k[0], 1'b0};
      sfr(1'b1, ext_mem_pkg::ADDR_TIMING, cfg[k]);
      sfr(1'b1, ext_mem_pkg::ADDR_AUX2, {k[0], 7'h40});
      sfr(1'b1, ext_mem_pkg::ADDR_AUX3, {4'h0, k[1], 3'h0});
      sfr(1'b1, ext_mem_pkg::ADDR_AUX1, 8'h02);
      sfr(1'b1, ext_mem_pkg::ADDR_DATA_HIGH, 8'hc0 + 8'(k));
      ptr(1'b0, 1'b1, a, a);
      movx(1'b1, 1'b0, 8'h00, 8'h30 + 8'(k));
      ptr(1'b0, 1'b1, a ^ 16'h0080, a ^ 16'h0080);
      // paged decoy write on the bus: same far address space, a different low byte
      movx(1'b1, 1'b1, a[7:0] ^ 8'h80, 8'h55);
      sfr(1'b1, ext_mem_pkg::ADDR_DATA_HIGH, 8'h00);
      ptr(1'b0, 1'b1, a, a);
      movx(1'b0, 1'b0, 8'h00, 8'h00);
      `CHK("bus low byte", 8'h30 + 8'(k), movx_rdata)
      `CHK("bus high byte", wide ? 8'hc0 + 8'(k) : 8'h00, data_high)
    end
    sfr(1'b1, ext_mem_pkg::ADDR_AUX1, 8'h00);
  endtask
  ////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_ptr();
    t_onchip_expanded_ram();
    t_ext();
    results();
  end
endmodule
bind external_data_memory_interface ext_mem_chk i_chk (.mclk, .rst, .sfr_req, .ptr_cmd, .ptr_value,
  .movx_req, .movx_busy, .movx_done, .pins);
